// ### hw/standby_power_down_control.sv
// Software and hardware standby power-down sequencer
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "standby_params.svh"

module standby_power_down_control
    import standby_pkg::*;
#(
    parameter int unsigned SETTLE_STATES_0 = `SETTLE_STATES_0,
    parameter int unsigned SETTLE_STATES_1 = `SETTLE_STATES_1,
    parameter int unsigned SETTLE_STATES_2 = `SETTLE_STATES_2,
    parameter int unsigned SETTLE_STATES_3 = `SETTLE_STATES_3,
    parameter int unsigned SETTLE_STATES_4 = `SETTLE_STATES_4,
    parameter int          N_EXT           = 3,
    parameter int          N_KEY           = 8
) (
    input  wire logic             clk,              // System clock
    input  wire logic             arst_n,           // Async reset, low
    input  wire logic [15:0]      addr,             // Register address
    input  wire logic [7:0]       wdata,            // Write data
    input  wire logic             we,               // Write strobe
    input  wire logic             re,               // Read strobe
    output logic      [7:0]       rdata,            // Read data
    input  wire logic             halt_exec,        // Halt instruction
    input  wire logic             nmi_pin,          // Nonmaskable input
    input  wire logic [N_EXT-1:0] external_request_pins, // Active low
    input  wire logic [N_KEY-1:0] key_sense_inputs, // Active low keys
    input  wire logic             chip_clear_pin_n, // Chip clear, low
    input  wire logic             standby_pin_n,    // Standby, low
    output pd_ctrl_t              ctrl,             // Clock and reset
    output logic                  onchip_ram_en,    // RAM enable
    output logic                  wake_service,     // Interrupt pulse
    output wake_src_t             wake_source       // Waking source
);

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser

    logic rst_meta_r;
    logic rst_n_r;

    // Release reset through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settling count decode

    // Map settle code to wait length
    function automatic logic [`SETTLE_W-1:0] settle_target(
        input logic [2:0] code
    );
        logic [`SETTLE_W-1:0] t;
        t = `SETTLE_W'(SETTLE_STATES_4);        // Codes 1xx
        case (code)
            `SETTLE_CODE_0: t = `SETTLE_W'(SETTLE_STATES_0);
            `SETTLE_CODE_1: t = `SETTLE_W'(SETTLE_STATES_1);
            `SETTLE_CODE_2: t = `SETTLE_W'(SETTLE_STATES_2);
            `SETTLE_CODE_3: t = `SETTLE_W'(SETTLE_STATES_3);
            default:        t = `SETTLE_W'(SETTLE_STATES_4);
        endcase
        return t;
    endfunction : settle_target

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    system_control_reg_t  sysctl_r;
    system_control_reg_t  sysctl_nxt;
    pd_state_t            st_r;
    pd_state_t            st_nxt;
    pd_ctrl_t             ctrl_nxt;
    wake_src_t            src_now;
    wake_src_t            src_nxt;
    logic                 nmi_prev_r;
    logic [N_EXT-1:0]     ext_prev_r;
    logic [N_KEY-1:0]     key_prev_r;
    logic                 clr_prev_r;
    logic [N_EXT-1:0]     ext_fall;
    logic                 key_fall;
    logic                 nmi_hit;
    logic                 clr_rise;
    logic                 wake_any;
    logic                 settle_start;
    logic                 settle_abort;
    logic                 settle_done;
    logic                 svc_nxt;
    logic                 reset_seq;
    logic                 sel_sysctl;
    logic                 sel_pdstat;
    logic                 sysctl_wr;
    logic [7:0]           rdata_nxt;
    logic [`SETTLE_W-1:0] settle_len;

    ////////////////////////////////////////////////////////////////////////
    // Pin history for edge detection

    // Previous pin levels
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            nmi_prev_r <= 1'b1;
            ext_prev_r <= '1;
            key_prev_r <= '1;
            clr_prev_r <= 1'b1;
        end else begin
            nmi_prev_r <= nmi_pin;
            ext_prev_r <= external_request_pins;
            key_prev_r <= key_sense_inputs;
            clr_prev_r <= chip_clear_pin_n;
        end
    end

    // Falling edges on the external request pins
    genvar gi;
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_ext
            assign ext_fall[gi] = ext_prev_r[gi] & ~external_request_pins[gi];
        end
    endgenerate

    // Wake events
    assign key_fall = |(key_prev_r & ~key_sense_inputs);
    assign nmi_hit  = sysctl_r.nonmaskable_edge_select
                    ? (~nmi_prev_r & nmi_pin)
                    : (nmi_prev_r & ~nmi_pin);
    assign clr_rise = ~clr_prev_r & chip_clear_pin_n;
    assign src_now  = '{nmi: nmi_hit, ext_req: ext_fall,
                        key_sense_request: key_fall};
    assign wake_any = |src_now;

    ////////////////////////////////////////////////////////////////////////
    // Settling wait

    // Length from the settle field
    assign settle_len   = settle_target(sysctl_r.settle_select_field);
    // Drop the wait when leaving settle early
    assign settle_abort = (st_r == ST_SETTLE) && (st_nxt != ST_SETTLE);

    // Count on the restarted oscillator
    settle_counter #(
        .W      (`SETTLE_W)
    ) u_settle (
        .clk    (clk),
        .rst_n  (rst_n_r),
        .start  (settle_start),
        .abort  (settle_abort),
        .target (settle_len),
        .done   (settle_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power-down state machine

    // Next state and one-cycle actions
    always_comb begin
        st_nxt       = st_r;
        settle_start = 1'b0;
        svc_nxt      = 1'b0;
        reset_seq    = 1'b0;
        if (!standby_pin_n) begin
            st_nxt = ST_HWSTBY;
        end else begin
            case (st_r)
                ST_RUN: begin
                    if (!chip_clear_pin_n) begin
                        st_nxt = ST_CLRWT;
                    end else if (halt_exec) begin
                        st_nxt = sysctl_r.standby_select_bit
                               ? ST_SWSTBY : ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (!chip_clear_pin_n) begin
                        st_nxt = ST_CLRWT;
                    end else if (wake_any) begin
                        st_nxt  = ST_RUN;
                        svc_nxt = 1'b1;
                    end
                end
                ST_SWSTBY: begin
                    if (!chip_clear_pin_n) begin
                        st_nxt = ST_CLRWT;
                    end else if (wake_any) begin
                        st_nxt       = ST_SETTLE;
                        settle_start = 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (!chip_clear_pin_n) begin
                        st_nxt = ST_CLRWT;
                    end else if (settle_done) begin
                        st_nxt  = ST_RUN;
                        svc_nxt = 1'b1;
                    end
                end
                ST_CLRWT: begin
                    if (clr_rise) begin
                        st_nxt    = ST_RUN;
                        reset_seq = 1'b1;
                    end
                end
                ST_HWSTBY: begin
                    st_nxt = ST_HWRCV;
                end
                ST_HWRCV: begin
                    if (clr_rise) begin
                        st_nxt    = ST_RUN;
                        reset_seq = 1'b1;
                    end
                end
                default: begin
                    st_nxt = ST_RUN;
                end
            endcase
        end
    end

    // Outputs follow the coming state
    always_comb begin
        ctrl_nxt.cpu_clk_en    = (st_nxt == ST_RUN);
        ctrl_nxt.module_clk_en = (st_nxt == ST_RUN)
                               | (st_nxt == ST_SLEEP);
        ctrl_nxt.osc_run       = (st_nxt != ST_SWSTBY)
                               & (st_nxt != ST_HWSTBY);
        ctrl_nxt.module_reset  = (st_nxt == ST_SWSTBY)
                               | (st_nxt == ST_HWSTBY)
                               | (st_nxt == ST_HWRCV)
                               | (st_nxt == ST_CLRWT);
        ctrl_nxt.cpu_reset     = (st_nxt == ST_CLRWT)
                               | (st_nxt == ST_HWRCV)
                               | (st_nxt == ST_HWSTBY);
        ctrl_nxt.port_hold     = (st_nxt == ST_SWSTBY)
                               | (st_nxt == ST_SETTLE);
        ctrl_nxt.port_float    = (st_nxt == ST_HWSTBY)
                               | (st_nxt == ST_HWRCV);
    end

    // Record the waking source
    assign src_nxt = (settle_start || (svc_nxt && st_r == ST_SLEEP))
                   ? src_now : wake_source;

    // State, control and wake outputs
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r         <= ST_RUN;
            ctrl         <= '{cpu_clk_en: 1'b1, module_clk_en: 1'b1,
                              osc_run: 1'b1, default: 1'b0};
            wake_service <= 1'b0;
            wake_source  <= '0;
        end else begin
            st_r         <= st_nxt;
            ctrl         <= ctrl_nxt;
            wake_service <= svc_nxt;
            wake_source  <= src_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    // Address decode
    assign sel_sysctl = (addr == `SYSCTL_OFFSET);
    assign sel_pdstat = (addr == `PDSTAT_OFFSET);
    // Only a running processor writes
    assign sysctl_wr  = we && sel_sysctl && (st_r == ST_RUN);

    // Control register next value
    always_comb begin
        sysctl_nxt = sysctl_r;
        if (reset_seq || st_r == ST_HWSTBY) begin
            sysctl_nxt = system_control_reg_t'(`SYSCTL_RESET);
        end else if (sysctl_wr) begin
            sysctl_nxt = system_control_reg_t'(wdata);
            sysctl_nxt.ext_reset_flag = sysctl_r.ext_reset_flag; // Read-only
        end
        // Standby bit only changes by write, reset or hardware standby
    end

    // Read data mux
    assign rdata_nxt = !re        ? 8'h00
                     : sel_sysctl ? 8'(sysctl_r)
                     : sel_pdstat ? {1'b0, st_r}
                     : 8'h00;

    // Register file and read data
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sysctl_r      <= system_control_reg_t'(`SYSCTL_RESET);
            rdata         <= 8'h00;
            onchip_ram_en <= 1'b1;
        end else begin
            sysctl_r      <= sysctl_nxt;
            rdata         <= rdata_nxt;
            onchip_ram_en <= sysctl_nxt.onchip_ram_enable;
        end
    end

endmodule : standby_power_down_control

// ### inc/standby_params.svh
// Offsets, reset values and settling counts of the standby power-down control
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH

`define SYSCTL_OFFSET    16'hffc4
`define PDSTAT_OFFSET    16'hffc6
`define SYSCTL_RESET     8'h09
`define SETTLE_W         18
`define SETTLE_STATES_0  8192
`define SETTLE_STATES_1  16384
`define SETTLE_STATES_2  32768
`define SETTLE_STATES_3  65536
`define SETTLE_STATES_4  131072
`define SETTLE_CODE_0    3'h0
`define SETTLE_CODE_1    3'h1
`define SETTLE_CODE_2    3'h2
`define SETTLE_CODE_3    3'h3

`endif

// ### inc/standby_pkg.sv
// Types shared by the standby power-down control
package standby_pkg;

    // System control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       standby_select_bit;
        logic [2:0] settle_select_field;
        logic       ext_reset_flag;
        logic       nonmaskable_edge_select;
        logic       host_if_enable;
        logic       onchip_ram_enable;
    } system_control_reg_t;

    // Power-down states, one-hot
    typedef enum logic [6:0] {
        ST_RUN    = 7'b000_0001,
        ST_SLEEP  = 7'b000_0010,
        ST_SWSTBY = 7'b000_0100,
        ST_SETTLE = 7'b000_1000,
        ST_CLRWT  = 7'b001_0000,
        ST_HWSTBY = 7'b010_0000,
        ST_HWRCV  = 7'b100_0000
    } pd_state_t;

    // Clock, reset and port controls to the rest of the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic module_clk_en;
        logic osc_run;
        logic module_reset;
        logic cpu_reset;
        logic port_hold;
        logic port_float;
    } pd_ctrl_t;

    // Which source woke the chip
    typedef struct packed {
        logic       nmi;
        logic [2:0] ext_req;
        logic       key_sense_request;
    } wake_src_t;

endpackage : standby_pkg

// ### hw/settle_counter.sv
// Oscillator settling wait counter
`timescale 1ns/1ps
`include "standby_params.svh"

module settle_counter #(
    parameter int W = `SETTLE_W
) (
    input  wire logic         clk,    // System clock
    input  wire logic         rst_n,  // Synchronised reset, active low
    input  wire logic         start,  // Begin a wait
    input  wire logic         abort,  // Drop a running wait
    input  wire logic [W-1:0] target, // Wait length in cycles
    output logic              done    // One-cycle end pulse
);

    logic [W-1:0] cnt_r;
    logic         busy_r;
    logic         last;

    // Last cycle of the wait
    assign last = busy_r && (cnt_r == target - W'(1));

    // Count cycles of the running oscillator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= last & ~abort;
            if (start) begin
                cnt_r  <= '0;
                busy_r <= 1'b1;
            end else if (abort || last) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end

endmodule : settle_counter

// ### dv/standby_checker_assertions.sv
// Port checks for the standby power-down control
`timescale 1ns/1ps

module standby_checker
    import standby_pkg::*;
#(
    parameter int N_EXT = 3,
    parameter int N_KEY = 8
) (
    input wire logic             clk,              // System clock
    input wire logic             arst_n,           // Async reset, low
    input wire logic [15:0]      addr,             // Register address
    input wire logic [7:0]       wdata,            // Write data
    input wire logic             we,               // Write strobe
    input wire logic             re,               // Read strobe
    input wire logic [7:0]       rdata,            // Read data
    input wire logic             halt_exec,        // Halt instruction
    input wire logic             nmi_pin,          // Nonmaskable input
    input wire logic [N_EXT-1:0] external_request_pins, // Requests
    input wire logic [N_KEY-1:0] key_sense_inputs, // Key inputs
    input wire logic             chip_clear_pin_n, // Chip clear
    input wire logic             standby_pin_n,    // Standby pin
    input wire pd_ctrl_t         ctrl,             // Clock and reset
    input wire logic             onchip_ram_en,    // RAM enable
    input wire logic             wake_service,     // Interrupt pulse
    input wire wake_src_t        wake_source       // Waking source
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Power-down entry and ports
    a_hw_entry: assert property (!standby_pin_n |-> ##[1:2] (ctrl.port_float
        && ctrl.cpu_reset && ctrl.module_reset && !ctrl.osc_run))
        else $error("standby pin low without hardware standby");
    a_float_halted: assert property (ctrl.port_float |->
        !ctrl.port_hold && !ctrl.cpu_clk_en)
        else $error("ports float while running or held");
    a_hold_stopped: assert property (ctrl.port_hold |-> !ctrl.port_float
        && !ctrl.cpu_clk_en && !ctrl.module_clk_en)
        else $error("held ports without stopped clocks");
    a_sw_entry: assert property ($rose(ctrl.port_hold) |->
        ctrl.module_reset && !ctrl.osc_run
        && ($past(halt_exec) || $past(halt_exec, 2)))
        else $error("software standby entered without halt");

    ////////////////////////////////////////////////////////////////////////
    // Wake-up, recovery and read data
    a_settle_wait: assert property ($fell(ctrl.module_reset)
        && ctrl.osc_run && !ctrl.cpu_reset && !ctrl.cpu_clk_en
        |-> !ctrl.cpu_clk_en [*8])
        else $error("clocks released before settling");
    a_wake_single: assert property (wake_service |=> !wake_service)
        else $error("wake pulse longer than one cycle");
    a_wake_resume: assert property (wake_service |-> ctrl.cpu_clk_en
        && ctrl.module_clk_en && !ctrl.port_hold)
        else $error("wake pulse without running clocks");
    a_clear_start: assert property ($fell(chip_clear_pin_n)
        && standby_pin_n |-> ##[1:2] (ctrl.cpu_reset && ctrl.osc_run))
        else $error("clear low did not start oscillator");
    a_clear_resume: assert property ($rose(chip_clear_pin_n)
        && standby_pin_n && ctrl.cpu_reset
        |-> ##[1:2] (ctrl.cpu_clk_en && !ctrl.cpu_reset))
        else $error("clear rise did not resume");
    a_rdata_quiet: assert property (!re |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    c_wake:  cover property (wake_service);
    c_float: cover property (ctrl.port_float);
    c_hold:  cover property (ctrl.port_hold);
endmodule : standby_checker

bind standby_power_down_control standby_checker #(
    .N_EXT(N_EXT), .N_KEY(N_KEY)
) chk_u (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .we(we),
    .re(re), .rdata(rdata), .halt_exec(halt_exec), .nmi_pin(nmi_pin),
    .external_request_pins(external_request_pins),
    .key_sense_inputs(key_sense_inputs),
    .chip_clear_pin_n(chip_clear_pin_n), .standby_pin_n(standby_pin_n),
    .ctrl(ctrl), .onchip_ram_en(onchip_ram_en),
    .wake_service(wake_service), .wake_source(wake_source)
);

// ### dv/pin_partner.sv
// Board model driving the standby, clear and wake pins
`timescale 1ns/1ps

module pin_partner (
    input  wire logic  clk,                   // System clock
    output logic       nmi_pin,               // Nonmaskable line
    output logic [2:0] external_request_pins, // Requests, pulled up
    output logic [7:0] key_sense_inputs,      // Keys, pulled up
    output logic       chip_clear_pin_n,      // Chip clear, low
    output logic       standby_pin_n          // Standby, low
);
    // Idle levels; boot pins are outside this model and never move
    initial begin
        nmi_pin = 1'b1;
        external_request_pins = 3'h7;
        key_sense_inputs = 8'hff;
        chip_clear_pin_n = 1'b1;
        standby_pin_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin actions, each launched right after a rising edge
    task automatic set_nmi(input logic lvl);
        @(posedge clk);
        nmi_pin <= lvl;
    endtask : set_nmi

    // Low pulse of three cycles, back to the pull-up level
    task automatic pulse_req(input int src);
        @(posedge clk);
        if (src < 5) external_request_pins[src-2] <= 1'b0;
        else key_sense_inputs[src-5] <= 1'b0;
        repeat (3) @(posedge clk);
        external_request_pins <= 3'h7;
        key_sense_inputs <= 8'hff;
    endtask : pulse_req

    task automatic clear_down;
        @(posedge clk);
        chip_clear_pin_n <= 1'b0;
    endtask : clear_down

    // Clear held low long enough for the oscillator
    task automatic clear_up(input int n);
        repeat (n) @(posedge clk);
        chip_clear_pin_n <= 1'b1;
    endtask : clear_up

    task automatic standby_pin_n_level(input logic lvl);
        @(posedge clk);
        standby_pin_n <= lvl;
    endtask : standby_pin_n_level
endmodule : pin_partner

// ### dv/testbench.sv
// Self-checking bench for the standby power-down control
`timescale 1ns/1ps

`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end end

module testbench;
    logic                    clk, arst_n, we, re, halt_exec, wake_service;
    logic [15:0]             addr;
    logic [7:0]              wdata, rdata, keys, d;
    logic [2:0]              ext;
    logic                    nmi, clr_n, standby_pin_n_n, ram_en, rise;
    logic [4:0]              ws_e;
    standby_pkg::pd_ctrl_t   ctrl;
    standby_pkg::wake_src_t  wsrc;
    logic [31:0]             seed = 32'hb572;
    int                      fail_count = 0;
    int                      samples_checked = 0;
    int                      cnt, c0;
    int                      n_tab[8] = '{8, 16, 32, 64, 128, 128, 128, 128};
    int                      codes[6] = '{0, 1, 2, 3, 4, 7};

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    standby_power_down_control #(.SETTLE_STATES_0(8), .SETTLE_STATES_1(16),
        .SETTLE_STATES_2(32), .SETTLE_STATES_3(64), .SETTLE_STATES_4(128)
    ) dut_u (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .we(we), .re(re), .rdata(rdata), .halt_exec(halt_exec),
        .nmi_pin(nmi), .external_request_pins(ext), .key_sense_inputs(keys),
        .chip_clear_pin_n(clr_n), .standby_pin_n(standby_pin_n_n), .ctrl(ctrl),
        .onchip_ram_en(ram_en), .wake_service(wake_service),
        .wake_source(wsrc));

    pin_partner partner_u (.clk(clk), .nmi_pin(nmi),
        .external_request_pins(ext), .key_sense_inputs(keys),
        .chip_clear_pin_n(clr_n), .standby_pin_n(standby_pin_n_n));

    ////////////////////////////////////////////////////////////////////////
    // Stimulus helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 `CHECK("rdata", e, rdata)
    endtask : chk_rd

    // Standby bit, settle code and edge bit, RAM disabled, then halt
    task automatic enter_sw(input logic [2:0] code, input logic eg);
        wr(16'hffc4, {1'b1, code, 1'b0, eg, 2'b00});
        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
        cyc(3);
        `CHECK("ctrl", 7'h0a, ctrl)
        chk_rd(16'hffc6, 8'h04);
    endtask : enter_sw

    task automatic wait_wake;
        cnt = 0;
        do begin
            @(posedge clk);
            #1 cnt++;
        end while (wake_service !== 1'b1 && cnt < 400);
        `CHECK("wake_service", 1'b1, wake_service)
    endtask : wait_wake

    task automatic complete_run;
        if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    initial begin
        #1_000_000;
        fail_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {arst_n, we, re, halt_exec} = '0;
        seed = lfsr(seed);
        addr = seed[15:0];
        wdata = seed[23:16];
        cyc(3);
        arst_n <= 1'b1;
        cyc(3);
        chk_rd(16'hffc4, 8'h09);
        `CHECK("ctrl", 7'h70, ctrl)
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = seed[7:0] & 8'h7f;
            wr(16'hffc4, d);
            chk_rd(16'hffc4, d | 8'h08);
            `CHECK("ram_en", d[0], ram_en)
        end
        chk_rd(16'h0010, 8'h00);
        // Settle length per code, relative to the shortest
        foreach (codes[k]) begin
            enter_sw(codes[k][2:0], 1'b0);
            fork
                partner_u.pulse_req(2);
                wait_wake();
            join
            if (k == 0) c0 = cnt;
            `CHECK("settle", n_tab[codes[k]] - n_tab[0], cnt - c0)
            `CHECK("settle_min", 1, int'(cnt >= n_tab[codes[k]]))
        end
        // Every wake source; nmi with both edge choices
        for (int s = 0; s < 13; s++) begin
            rise = (s == 1);
            partner_u.set_nmi(rise);
            enter_sw(3'h0, rise);
            if (s < 2) begin
                partner_u.set_nmi(!rise);
                cyc(6);
                `CHECK("ctrl", 7'h0a, ctrl)
                fork
                    partner_u.set_nmi(rise);
                    wait_wake();
                join
            end else begin
                fork
                    partner_u.pulse_req(s);
                    wait_wake();
                join
            end
            ws_e = (s < 2) ? 5'h10 : (s < 5) ? 5'h01 << (s - 1) : 5'h01;
            `CHECK("wake_source", ws_e, wsrc)
            `CHECK("ctrl", 7'h70, ctrl)
            chk_rd(16'hffc4, {1'b1, 4'h1, rise, 2'b00});
        end
        partner_u.set_nmi(1'b1);
        // Chip clear out of software standby
        enter_sw(3'h0, 1'b0);
        partner_u.clear_down();
        cyc(3);
        `CHECK("osc_rst", 2'b11, {ctrl.osc_run, ctrl.cpu_reset})
        chk_rd(16'hffc6, 8'h10);
        partner_u.clear_up(10);
        cyc(3);
        `CHECK("ctrl", 7'h70, ctrl)
        chk_rd(16'hffc4, 8'h09);
        // Hardware standby from software standby, then from the chip clear wait
        for (int k = 0; k < 2; k++) begin
            wr(16'hffc4, 8'h08);
            if (k == 0) enter_sw(3'h0, 1'b0);
            else partner_u.clear_down();
            partner_u.standby_pin_n_level(1'b0);
            cyc(3);
            `CHECK("hw", 4'b0111, {ctrl.osc_run, ctrl.module_reset, ctrl.cpu_reset, ctrl.port_float})
            if (k == 0) partner_u.clear_down();
            partner_u.standby_pin_n_level(1'b1);
            cyc(3);
            `CHECK("osc_clk", 2'b10, {ctrl.osc_run, ctrl.cpu_clk_en})
            partner_u.clear_up(10);
            cyc(3);
            `CHECK("ctrl", 7'h70, ctrl)
            chk_rd(16'hffc4, 8'h09);
        end
        complete_run();
    end
endmodule : testbench
